//--- trace_lock_pkg.sv
/*
 trace_lock_pkg: offsets, field positions, reset values and the unlock key
 of the trace source lock and identification register bank.
 assumes: word-aligned byte offsets within a 4 KiB register page.
*/
`default_nettype none

package trace_lock_pkg;

   // key that opens the configuration registers
   localparam logic [31:0] UNLOCK_KEY     = 32'hC5ACCE55;

   // byte offsets of the registers
   localparam logic [11:0] OFS_PORT_EN    = 12'hE00;
   localparam logic [11:0] OFS_TRIG_EN    = 12'hE20;
   localparam logic [11:0] OFS_PORT_SEL   = 12'hE60;
   localparam logic [11:0] OFS_MAST_SEL   = 12'hE64;
   localparam logic [11:0] OFS_TRACE_CTL  = 12'hE80;
   localparam logic [11:0] OFS_SYNC       = 12'hE90;
   localparam logic [11:0] OFS_LOCK_KEY   = 12'hFB0;
   localparam logic [11:0] OFS_LOCK_STATE = 12'hFB4;
   localparam logic [11:0] OFS_AUTH       = 12'hFB8;
   localparam logic [11:0] OFS_ARCH       = 12'hFBC;
   localparam logic [11:0] OFS_PORT_CFG   = 12'hFC8;
   localparam logic [11:0] OFS_DEV_CLASS  = 12'hFCC;
   localparam logic [11:0] OFS_CID0       = 12'hFF0;
   localparam logic [11:0] OFS_CID1       = 12'hFF4;
   localparam logic [11:0] OFS_CID2       = 12'hFF8;
   localparam logic [11:0] OFS_CID3       = 12'hFFC;

   // field positions
   localparam int LS_IMPL_BIT    = 0;
   localparam int LS_LOCKED_BIT  = 1;
   localparam int LS_WIDTH_BIT   = 2;
   localparam int TCR_EN_BIT     = 0;
   localparam int TCR_SID_LSB    = 16;
   localparam int SID_WIDTH      = 7;
   localparam int PORT_CNT_WIDTH = 17;

   // values after reset
   localparam logic        RST_LOCKED = 1'b1;
   localparam logic [31:0] RST_CFG    = 32'h00000000;
   localparam logic [31:0] RST_SYNC   = 32'h00000400;

endpackage : trace_lock_pkg

`default_nettype wire

//--- trace_lock_regs.sv
/*
 trace_lock_regs: write lock, lock status, identification registers and
 the live configuration registers of a software-driven trace source.
 assumes: one Avalon-MM master on ref_clk_i; dbg_access_i is a same-clock
 sideband that marks a debugger access for the whole request;
 auth_state_i comes from pins and is synchronised here.
*/
// Implementation choice: the Avalon-MM slave port.
`default_nettype none

// Operation
// R01: lock guards all configuration, not the key
// R02: locked software writes are silently dropped
// R03: debugger writes and all reads bypass lock
// R04: magic key unlocks, any other value locks
// R05: software unlocks, configures, then relocks
// R06: status bit 1 shows locked state
// R07: debugger sees locked bit as zero
// R08: lock is set out of reset
// R09: bit 0 shows lock implemented; debugger keys ignored
// R10: bit 2 reads zero, upper bits reserved
// R11: read-only authentication status for four types
// R12: designer code and presence flag, else zero
// R13: revision and architecture identifier fields
// R14: port count field, zero means 32; code reports NUM_PORTS as is, so 32 reads 32 and the field never reads zero
// R15: constant sub-type and major type codes
// R16: four fixed component identity bytes
// R17: live registers writable while tracing enabled
// R18: software keeps stream identifier while enabled
// R19: select and enable writes apply immediately
// R20: software clears enables before changing bank
// R21: sync period changes at period end
// R22: one lock flop gates configuration writes
module trace_lock_regs #(
   parameter int unsigned NUM_PORTS     = 32,
   parameter logic [10:0] ARCH_DESIGNER = 11'h155, // arbitrary value
   parameter logic        ARCH_PRESENT  = 1'b1,
   parameter logic [3:0]  ARCH_REVISION = 4'h2,    // arbitrary value
   parameter logic [15:0] ARCH_ID       = 16'h5A5A, // arbitrary value
   parameter logic [3:0]  DEV_SUB       = 4'hA,    // arbitrary value
   parameter logic [3:0]  DEV_MAJOR     = 4'hC,    // arbitrary value
   parameter logic [7:0]  CID_BYTE0     = 8'h11,   // arbitrary value
   parameter logic [7:0]  CID_BYTE1     = 8'h22,   // arbitrary value
   parameter logic [7:0]  CID_BYTE2     = 8'h33,   // arbitrary value
   parameter logic [7:0]  CID_BYTE3     = 8'h44    // arbitrary value
) (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic        dbg_access_i,
   input  wire logic [7:0]  auth_state_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             locked_o,
   output logic             trace_enable_o,
   output logic      [6:0]  stream_id_o,
   output logic      [31:0] port_enable_o,
   output logic      [31:0] port_trigger_enable_o,
   output logic      [31:0] port_select_o,
   output logic      [31:0] master_select_o,
   output logic      [31:0] sync_period_o
);

   // reject port counts of zero or above 65536
   if (NUM_PORTS == 0 || NUM_PORTS > 65536) begin : g_bad_ports
      $error("NUM_PORTS must lie in 1..65536");
   end

   typedef struct packed {
      logic        wait_req;
      logic [31:0] rdata;
      logic        locked;
      logic [31:0] tcr;
      logic [31:0] port_en;
      logic [31:0] trig_en;
      logic [31:0] port_sel;
      logic [31:0] mast_sel;
      logic [31:0] sync_pend;
      logic [31:0] sync_act;
      logic [31:0] sync_cnt;
      logic [7:0]  auth_s1;
      logic [7:0]  auth_s2;
   } state_s;

   localparam state_s STATE_RST = '{
      wait_req:  1'b1,
      rdata:     32'h00000000,
      locked:    trace_lock_pkg::RST_LOCKED,
      tcr:       trace_lock_pkg::RST_CFG,
      port_en:   trace_lock_pkg::RST_CFG,
      trig_en:   trace_lock_pkg::RST_CFG,
      port_sel:  trace_lock_pkg::RST_CFG,
      mast_sel:  trace_lock_pkg::RST_CFG,
      sync_pend: trace_lock_pkg::RST_SYNC,
      sync_act:  trace_lock_pkg::RST_SYNC,
      sync_cnt:  trace_lock_pkg::RST_SYNC,
      auth_s1:   8'h00,
      auth_s2:   8'h00
   };

   // absent architecture register reads all zero
   localparam logic [31:0] ARCH_WORD = ARCH_PRESENT ?
      {ARCH_DESIGNER, 1'b1, ARCH_REVISION, ARCH_ID} : 32'h00000000; // [R12] [R13]
   localparam logic [16:0] PORT_CNT  = 17'(NUM_PORTS);

   state_s      st_r;
   state_s      st_nxt;
   logic [11:0] byte_addr;
   logic        acc;

   assign byte_addr = {avs_address_i, 2'b00};
   // request is answered in the cycle waitrequest stands low
   assign acc = !st_r.wait_req && (avs_read_i || avs_write_i);

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // read decode; unmapped offsets read zero
   function automatic logic [31:0] read_word(input logic [11:0] a,
                                             input logic        dbg,
                                             input state_s      s);
      logic [31:0] r;
      r = 32'h00000000;
      if (a == trace_lock_pkg::OFS_LOCK_STATE) begin
         r[trace_lock_pkg::LS_IMPL_BIT]   = !dbg;            // [R09]
         r[trace_lock_pkg::LS_LOCKED_BIT] = !dbg && s.locked; // [R06] [R07]
         r[trace_lock_pkg::LS_WIDTH_BIT]  = 1'b0;            // [R10]
      end else if (a == trace_lock_pkg::OFS_AUTH) begin
         r[7:0] = s.auth_s2; // [R11]
      end else if (a == trace_lock_pkg::OFS_ARCH) begin
         r = ARCH_WORD;
      end else if (a == trace_lock_pkg::OFS_PORT_CFG) begin
         r[16:0] = PORT_CNT; // [R14]
      end else if (a == trace_lock_pkg::OFS_DEV_CLASS) begin
         r[7:0] = {DEV_SUB, DEV_MAJOR}; // [R15]
      end else if (a == trace_lock_pkg::OFS_CID0) begin
         r[7:0] = CID_BYTE0; // [R16]
      end else if (a == trace_lock_pkg::OFS_CID1) begin
         r[7:0] = CID_BYTE1; // [R16]
      end else if (a == trace_lock_pkg::OFS_CID2) begin
         r[7:0] = CID_BYTE2; // [R16]
      end else if (a == trace_lock_pkg::OFS_CID3) begin
         r[7:0] = CID_BYTE3; // [R16]
      end else if (a == trace_lock_pkg::OFS_PORT_EN) begin
         r = s.port_en;
      end else if (a == trace_lock_pkg::OFS_TRIG_EN) begin
         r = s.trig_en;
      end else if (a == trace_lock_pkg::OFS_PORT_SEL) begin
         r = s.port_sel;
      end else if (a == trace_lock_pkg::OFS_MAST_SEL) begin
         r = s.mast_sel;
      end else if (a == trace_lock_pkg::OFS_TRACE_CTL) begin
         r = s.tcr;
      end else if (a == trace_lock_pkg::OFS_SYNC) begin
         r = s.sync_pend;
      end
      return r;
   endfunction : read_word

   // next state: bus handshake, lock, configuration, sync staging
   always_comb begin
      st_nxt = st_r;
      // auth pins pass two flops before use
      st_nxt.auth_s1 = auth_state_i;
      st_nxt.auth_s2 = st_r.auth_s1;
      if (st_r.wait_req) begin
         if (avs_read_i || avs_write_i) begin
            st_nxt.wait_req = 1'b0;
            if (avs_read_i) begin
               st_nxt.rdata = read_word(byte_addr, dbg_access_i, st_r); // [R03]
            end
         end
      end else begin
         st_nxt.wait_req = 1'b1;
         if (avs_write_i) begin
            if (byte_addr == trace_lock_pkg::OFS_LOCK_KEY) begin
               // key stays writable; debugger keys are ignored
               if (!dbg_access_i) begin // [R01] [R09]
                  st_nxt.locked = !(avs_writedata_i == trace_lock_pkg::UNLOCK_KEY
                                    && avs_byteenable_i == 4'hF); // [R04] [R22]
               end
            end else if (dbg_access_i || !st_r.locked) begin // [R02] [R03] [R22]
               // live writes apply at once, even while tracing [R17] [R19]
               if (byte_addr == trace_lock_pkg::OFS_PORT_EN) begin
                  st_nxt.port_en = merge(st_r.port_en, avs_writedata_i,
                                         avs_byteenable_i);
               end else if (byte_addr == trace_lock_pkg::OFS_TRIG_EN) begin
                  st_nxt.trig_en = merge(st_r.trig_en, avs_writedata_i,
                                         avs_byteenable_i);
               end else if (byte_addr == trace_lock_pkg::OFS_PORT_SEL) begin
                  st_nxt.port_sel = merge(st_r.port_sel, avs_writedata_i,
                                          avs_byteenable_i);
               end else if (byte_addr == trace_lock_pkg::OFS_MAST_SEL) begin
                  st_nxt.mast_sel = merge(st_r.mast_sel, avs_writedata_i,
                                          avs_byteenable_i);
               end else if (byte_addr == trace_lock_pkg::OFS_TRACE_CTL) begin
                  // identifier not guarded; software leaves it while enabled
                  st_nxt.tcr = merge(st_r.tcr, avs_writedata_i,
                                     avs_byteenable_i); // [R18]
               end else if (byte_addr == trace_lock_pkg::OFS_SYNC) begin
                  st_nxt.sync_pend = merge(st_r.sync_pend, avs_writedata_i,
                                           avs_byteenable_i);
               end
            end
         end
      end
      // new period only at the end of the running one while enabled
      if (!st_r.tcr[trace_lock_pkg::TCR_EN_BIT]) begin
         st_nxt.sync_act = st_r.sync_pend;
         st_nxt.sync_cnt = st_r.sync_pend;
      end else if (st_r.sync_cnt == 32'h00000000) begin
         st_nxt.sync_act = st_r.sync_pend; // [R21]
         st_nxt.sync_cnt = st_r.sync_pend;
      end else begin
         st_nxt.sync_cnt = st_r.sync_cnt - 32'h00000001;
      end
   end

   // single state register
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_r <= STATE_RST; // [R08]
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign avs_readdata_o        = st_r.rdata;
   assign avs_waitrequest_o     = st_r.wait_req;
   assign locked_o              = st_r.locked;
   assign trace_enable_o        = st_r.tcr[trace_lock_pkg::TCR_EN_BIT];
   assign stream_id_o           = st_r.tcr[trace_lock_pkg::TCR_SID_LSB +: 7];
   assign port_enable_o         = st_r.port_en;
   assign port_trigger_enable_o = st_r.trig_en;
   assign port_select_o         = st_r.port_sel;
   assign master_select_o       = st_r.mast_sel;
   assign sync_period_o         = st_r.sync_act;

   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   logic sw_key_wr;
   logic dbg_key_wr;
   logic en_wr;
   assign sw_key_wr  = acc && avs_write_i && !dbg_access_i
                       && byte_addr == trace_lock_pkg::OFS_LOCK_KEY;
   assign dbg_key_wr = acc && avs_write_i && dbg_access_i
                       && byte_addr == trace_lock_pkg::OFS_LOCK_KEY;
   assign en_wr      = acc && avs_write_i && avs_byteenable_i == 4'hF
                       && byte_addr == trace_lock_pkg::OFS_PORT_EN;

   property p_rst_locked;
      $fell(sys_rst_i) |-> st_r.locked && avs_waitrequest_o;
   endproperty
   a_rst_locked: assert property (p_rst_locked) else $error("not locked after reset"); // [R08]

   property p_unlock;
      sw_key_wr && avs_byteenable_i == 4'hF
         && avs_writedata_i == trace_lock_pkg::UNLOCK_KEY |=> !locked_o;
   endproperty
   a_unlock: assert property (p_unlock) else $error("key did not unlock"); // [R04]

   property p_relock;
      sw_key_wr && avs_writedata_i != trace_lock_pkg::UNLOCK_KEY |=> locked_o;
   endproperty
   a_relock: assert property (p_relock) else $error("other value did not lock"); // [R04]

   property p_dbg_key;
      dbg_key_wr |=> $stable(locked_o);
   endproperty
   a_dbg_key: assert property (p_dbg_key) else $error("debugger key changed lock"); // [R09]

   property p_discard;
      en_wr && !dbg_access_i && locked_o |=> $stable(port_enable_o);
   endproperty
   a_discard: assert property (p_discard) else $error("locked write took effect"); // [R02]

   property p_dbg_write;
      en_wr && dbg_access_i |=> port_enable_o == $past(avs_writedata_i);
   endproperty
   a_dbg_write: assert property (p_dbg_write) else $error("debugger write lost"); // [R03]

   property p_sw_state;
      acc && avs_read_i && !dbg_access_i
         && byte_addr == trace_lock_pkg::OFS_LOCK_STATE
         |-> avs_readdata_o == {29'h0, 1'b0, locked_o, 1'b1};
   endproperty
   a_sw_state: assert property (p_sw_state) else $error("bad lock status"); // [R06]

   property p_dbg_state;
      acc && avs_read_i && dbg_access_i
         && byte_addr == trace_lock_pkg::OFS_LOCK_STATE |-> avs_readdata_o == 32'h0;
   endproperty
   a_dbg_state: assert property (p_dbg_state) else $error("bad debugger status"); // [R07]

   property p_arch;
      acc && avs_read_i && byte_addr == trace_lock_pkg::OFS_ARCH
         |-> avs_readdata_o == ARCH_WORD;
   endproperty
   a_arch: assert property (p_arch) else $error("bad architecture word"); // [R12]

   property p_answer;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
         avs_waitrequest_o;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late"); // request answered next cycle, waitrequest then high again

   property p_sync_hold;
      trace_enable_o && st_r.sync_cnt != 32'h0 |=> $stable(sync_period_o);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync changed mid period"); // [R21]

   // period swap lands exactly when the running count runs out
   property p_sync_load;
      trace_enable_o && st_r.sync_cnt == 32'h00000000
         |=> sync_period_o == $past(st_r.sync_pend);
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("sync not loaded at end"); // [R21]

   // unlocked software write reaches the live output on the next edge
   property p_sw_write;
      en_wr && !dbg_access_i && !locked_o |=> port_enable_o == $past(avs_writedata_i);
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("unlocked write lost"); // [R19]

   // only a software key write may move the lock flop
   property p_key_hold;
      !sw_key_wr |=> $stable(locked_o);
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("lock moved without key"); // [R22]

   property p_rsvd_state;
      acc && avs_read_i && byte_addr == trace_lock_pkg::OFS_LOCK_STATE
         |-> avs_readdata_o[31:2] == 30'h00000000;
   endproperty
   a_rsvd_state: assert property (p_rsvd_state) else $error("bad status bits"); // [R10]

   property p_port_cnt;
      acc && avs_read_i && byte_addr == trace_lock_pkg::OFS_PORT_CFG
         |-> avs_readdata_o == {15'h0000, PORT_CNT};
   endproperty
   a_port_cnt: assert property (p_port_cnt) else $error("bad port count"); // [R14]

   property p_dev_class;
      acc && avs_read_i && byte_addr == trace_lock_pkg::OFS_DEV_CLASS
         |-> avs_readdata_o == {24'h000000, DEV_SUB, DEV_MAJOR};
   endproperty
   a_dev_class: assert property (p_dev_class) else $error("bad device class"); // [R15]

   property p_cid3;
      acc && avs_read_i && byte_addr == trace_lock_pkg::OFS_CID3
         |-> avs_readdata_o == {24'h000000, CID_BYTE3};
   endproperty
   a_cid3: assert property (p_cid3) else $error("bad identity byte"); // [R16]

   c_unlock: cover property (sw_key_wr ##2 !locked_o);
   c_discard: cover property (en_wr && locked_o && !dbg_access_i);
   c_dbg_state: cover property (acc && avs_read_i && dbg_access_i && locked_o);
   c_sync_load: cover property (trace_enable_o && st_r.sync_cnt == 32'h0);
   c_dbg_write: cover property (en_wr && dbg_access_i && locked_o);

endmodule : trace_lock_regs

`default_nettype wire

//--- tb_trace_source_lock_and_ident.sv
/*
 tb_trace_source_lock_and_ident: directed bench for the trace source lock
 and identification register bank, driven over its Avalon-MM port.
 assumes: trace_lock_pkg compiled first; one clock, synchronous reset.
*/
`default_nettype none

module tb_trace_source_lock_and_ident;
   timeunit 1ns;
   timeprecision 1ps;

   // identity values handed to the design
   localparam logic [10:0] T_DESIGNER = 11'h2A1; // arbitrary value
   localparam logic [3:0]  T_REV      = 4'h5;    // arbitrary value
   localparam logic [15:0] T_ARCH     = 16'h1234; // arbitrary value
   localparam logic [3:0]  T_SUB      = 4'h9;    // arbitrary value
   localparam logic [3:0]  T_MAJOR    = 4'h7;    // arbitrary value
   localparam logic [31:0] T_CID      = 32'h78563412; // arbitrary value

   logic        ref_clk_i        = 1'b0;
   logic        sys_rst_i        = 1'b1;
   logic [9:0]  avs_address_i    = 10'h000;
   logic        avs_read_i       = 1'b0;
   logic        avs_write_i      = 1'b0;
   logic [31:0] avs_writedata_i  = 32'h00000000;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic        dbg_access_i     = 1'b0;
   logic [7:0]  auth_state_i     = 8'hA5;
   logic [31:0] avs_readdata_o, port_enable_o, port_trigger_enable_o;
   logic [31:0] port_select_o, master_select_o, sync_period_o;
   logic        avs_waitrequest_o, locked_o, trace_enable_o;
   logic [6:0]  stream_id_o;
   logic [31:0] rd, got;
   int          n_fail = 0;
   int          total_checks = 0;

   trace_lock_regs #(.NUM_PORTS(32), .ARCH_DESIGNER(T_DESIGNER), .ARCH_PRESENT(1'b1),
      .ARCH_REVISION(T_REV), .ARCH_ID(T_ARCH), .DEV_SUB(T_SUB), .DEV_MAJOR(T_MAJOR),
      .CID_BYTE0(T_CID[7:0]), .CID_BYTE1(T_CID[15:8]), .CID_BYTE2(T_CID[23:16]),
      .CID_BYTE3(T_CID[31:24])) i_dut (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .dbg_access_i(dbg_access_i), .auth_state_i(auth_state_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .locked_o(locked_o), .trace_enable_o(trace_enable_o), .stream_id_o(stream_id_o),
      .port_enable_o(port_enable_o), .port_trigger_enable_o(port_trigger_enable_o),
      .port_select_o(port_select_o), .master_select_o(master_select_o),
      .sync_period_o(sync_period_o));

   // free-running 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string what);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask : chk_word

   // holds the request until waitrequest is sampled low; bounded wait
   task automatic wait_answer();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20) begin
         n_fail++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
         final_report();
      end
   endtask : wait_answer

   // write, then step 1 ns into the cycle where the target output has settled
   task automatic bus_wr(input logic [11:0] ofs, input logic [31:0] d,
                         input logic [3:0] be, input logic dbg);
      @(posedge ref_clk_i);
      avs_address_i    <= ofs[11:2];
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      dbg_access_i     <= dbg;
      avs_write_i      <= 1'b1;
      wait_answer();
      avs_write_i      <= 1'b0;
      #1;
   endtask : bus_wr

   // read data taken at the same edge that sees waitrequest low
   task automatic bus_rd(input logic [11:0] ofs, input logic dbg, output logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= ofs[11:2];
      dbg_access_i  <= dbg;
      avs_read_i    <= 1'b1;
      wait_answer();
      d = avs_readdata_o;
      avs_read_i    <= 1'b0;
   endtask : bus_rd

   // main sequence
   initial begin
      logic [11:0] cfg_ofs [4];
      logic [31:0] cfg_val [4];
      logic [11:0] id_ofs [9];
      logic [31:0] id_exp [9];
      int          n;
      cfg_ofs = '{trace_lock_pkg::OFS_PORT_EN, trace_lock_pkg::OFS_TRIG_EN,
                  trace_lock_pkg::OFS_PORT_SEL, trace_lock_pkg::OFS_MAST_SEL};
      cfg_val = '{32'h0000000F, 32'h00000003, 32'h00100001, 32'h00000007};
      id_ofs = '{trace_lock_pkg::OFS_ARCH, trace_lock_pkg::OFS_PORT_CFG,
                 trace_lock_pkg::OFS_DEV_CLASS, trace_lock_pkg::OFS_AUTH,
                 trace_lock_pkg::OFS_CID0, trace_lock_pkg::OFS_CID1,
                 trace_lock_pkg::OFS_CID2, trace_lock_pkg::OFS_CID3, 12'h004};
      id_exp = '{{T_DESIGNER, 1'b1, T_REV, T_ARCH}, 32'h00000020,
                 {24'h000000, T_SUB, T_MAJOR}, 32'h000000A5, {24'h0, T_CID[7:0]},
                 {24'h0, T_CID[15:8]}, {24'h0, T_CID[23:16]}, {24'h0, T_CID[31:24]},
                 32'h00000000};
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk_word({31'h0, locked_o}, 32'h00000001, "locked after reset");
      chk_word(sync_period_o, 32'h00000400, "sync after reset");
      bus_rd(trace_lock_pkg::OFS_LOCK_STATE, 1'b0, rd);
      chk_word(rd, 32'h00000003, "software lock state");
      bus_rd(trace_lock_pkg::OFS_LOCK_STATE, 1'b1, rd);
      chk_word(rd, 32'h00000000, "debugger lock state");
      $display("test reset_state done");
      // locked: software dropped, debugger passes, debugger key ignored
      bus_wr(trace_lock_pkg::OFS_PORT_EN, 32'hFFFFFFFF, 4'hF, 1'b0);
      chk_word(port_enable_o, 32'h00000000, "locked write dropped");
      bus_wr(trace_lock_pkg::OFS_PORT_EN, 32'h00000001, 4'hF, 1'b1);
      chk_word(port_enable_o, 32'h00000001, "debugger write");
      bus_rd(trace_lock_pkg::OFS_PORT_EN, 1'b0, rd);
      chk_word(rd, 32'h00000001, "locked read");
      bus_wr(trace_lock_pkg::OFS_LOCK_KEY, trace_lock_pkg::UNLOCK_KEY, 4'hF, 1'b1);
      chk_word({31'h0, locked_o}, 32'h00000001, "debugger key ignored");
      $display("test locked_access done");
      // key handling, partial key locks again
      bus_wr(trace_lock_pkg::OFS_LOCK_KEY, trace_lock_pkg::UNLOCK_KEY, 4'hF, 1'b0);
      chk_word({31'h0, locked_o}, 32'h00000000, "unlocked");
      bus_rd(trace_lock_pkg::OFS_LOCK_STATE, 1'b0, rd);
      chk_word(rd, 32'h00000001, "unlocked state");
      bus_wr(trace_lock_pkg::OFS_LOCK_KEY, trace_lock_pkg::UNLOCK_KEY, 4'h7, 1'b0);
      chk_word({31'h0, locked_o}, 32'h00000001, "partial key locks");
      bus_wr(trace_lock_pkg::OFS_LOCK_KEY, trace_lock_pkg::UNLOCK_KEY, 4'hF, 1'b0);
      $display("test key done");
      // config writes apply at once, one register at a time
      for (int i = 0; i < 4; i++) begin
         bus_wr(cfg_ofs[i], cfg_val[i], 4'hF, 1'b0);
         case (i)
            0: got = port_enable_o;
            1: got = port_trigger_enable_o;
            2: got = port_select_o;
            default: got = master_select_o;
         endcase
         chk_word(got, cfg_val[i], "config output");
         bus_rd(cfg_ofs[i], 1'b0, rd);
         chk_word(rd, cfg_val[i], "config readback");
      end
      bus_wr(trace_lock_pkg::OFS_PORT_SEL, 32'hAABBCCDD, 4'h3, 1'b0);
      chk_word(port_select_o, 32'h0010CCDD, "lane merge");
      $display("test config done");
      // enable tracing, then move bank while enabled
      bus_wr(trace_lock_pkg::OFS_TRACE_CTL, 32'h005A0001, 4'hF, 1'b0);
      chk_word({24'h0, trace_enable_o, stream_id_o}, 32'h000000DA, "trace control");
      bus_wr(trace_lock_pkg::OFS_PORT_EN, 32'h00000000, 4'hF, 1'b0);
      chk_word(port_enable_o, 32'h00000000, "enable cleared");
      bus_wr(trace_lock_pkg::OFS_PORT_SEL, 32'h00300001, 4'hF, 1'b0);
      chk_word(port_select_o, 32'h00300001, "select while enabled");
      bus_wr(trace_lock_pkg::OFS_PORT_EN, 32'h80000000, 4'hF, 1'b0);
      chk_word(port_enable_o, 32'h80000000, "enable while enabled");
      $display("test bank_move done");
      // sync period staged while enabled, direct while disabled
      bus_wr(trace_lock_pkg::OFS_SYNC, 32'h00000020, 4'hF, 1'b0);
      chk_word(sync_period_o, 32'h00000400, "sync held in period");
      n = 0;
      while (sync_period_o !== 32'h00000020 && n < 1100) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk_word(sync_period_o, 32'h00000020, "sync at period end");
      bus_wr(trace_lock_pkg::OFS_TRACE_CTL, 32'h005A0000, 4'hF, 1'b0);
      chk_word({24'h0, trace_enable_o, stream_id_o}, 32'h0000005A, "id kept");
      bus_wr(trace_lock_pkg::OFS_SYNC, 32'h00000030, 4'hF, 1'b0);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk_word(sync_period_o, 32'h00000030, "sync when disabled");
      $display("test sync done");
      // relock with zero
      bus_wr(trace_lock_pkg::OFS_LOCK_KEY, 32'h00000000, 4'hF, 1'b0);
      chk_word({31'h0, locked_o}, 32'h00000001, "relocked");
      bus_wr(trace_lock_pkg::OFS_PORT_EN, 32'h0000000F, 4'hF, 1'b0);
      chk_word(port_enable_o, 32'h80000000, "relocked write dropped");
      $display("test relock done");
      // identity table; read-only and unmapped writes have no effect
      bus_wr(trace_lock_pkg::OFS_PORT_CFG, 32'hFFFFFFFF, 4'hF, 1'b1);
      bus_wr(12'h004, 32'hFFFFFFFF, 4'hF, 1'b1);
      for (int i = 0; i < 9; i++) begin
         bus_rd(id_ofs[i], 1'b0, rd);
         chk_word(rd, id_exp[i], "identity read");
      end
      $display("test identity done");
      final_report();
   end
endmodule : tb_trace_source_lock_and_ident

`default_nettype wire
